// *** cpu_pipeline_stage_sequencer.sv ***
`timescale 1ns/10ps
// Contract
// - Arithmetic ops take five stages
// - Imm32 move: two execute, one idle slot
// - Signed divide: 35 execute stages
// - Unsigned divide: 34 execute stages
// - Interrupt aborts divide, restarts at divide
// - Saturating ops take five stages
// - Logic and shift ops take five stages
// - Branches resolve target in decode
// - Failed branch: one clock, no discard
// - Taken branch: two clocks, discard next
// - Flag write before taken branch: three clocks
// - Jumps discard next; link writes back
// - Bit modify: two execute, two memory
// - Bit test: one read, three clocks
// - Table call: memory, execute, discard
// - Interrupt toggle ops never sample requests
// - Frame ops: memory phase n plus one
// - Halt holds next decode until released
// - Saved-PC read after write waits
// - Interrupt return: two decodes, discard two
// - Switch: execute, memory, execute
// - Trap detects code, then makes address
module cpu_pipeline_stage_sequencer
   import seq_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic issue_valid,
   input wire logic [4:0] issue_op,
   input wire logic [31:0] issue_pc,
   input wire logic [15:0] issue_code,
   input wire logic cond_true,
   input wire logic prev_writes_status,
   input wire logic prev_writes_saved_pc,
   input wire logic reads_saved_pc,
   input wire logic [4:0] list_count,
   input wire logic frame_branch,
   input wire logic irq_pending,
   input wire logic halt_release,
   output logic issue_ready,
   output logic fetch_cancel,
   output logic ex_stage,
   output logic mem_stage,
   output logic fwd_stage,
   output logic wb_write,
   output logic irq_taken,
   output logic [31:0] return_pc,
   output logic div_abort,
   output logic trap_valid,
   output logic [7:0] trap_vector,
   output logic instr_done
);
   typedef struct packed {
      stage_t st;
      op_t op;
      logic [5:0] ex_left;
      logic [5:0] mem_left;
      logic [4:0] wait_left;
      logic [1:0] discard;
      logic [31:0] pc;
      logic [15:0] code;
      logic second_mem;
      logic ready;
      logic cancel;
      logic ex_o;
      logic mem_o;
      logic fwd_o;
      logic wb_o;
      logic irq_o;
      logic [31:0] ret_o;
      logic abort_o;
      logic trap_o;
      logic [7:0] vec_o;
      logic done_o;
   } state_t;
   state_t q, n;
   seq_if act();

   stage_tracker u_tracker (
      .clk(clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .act(act)
   );
   assign act.ex_active = q.ex_o;
   assign act.mem_active = q.mem_o;
   assign act.wb_active = q.wb_o;

   function automatic logic is_trap_code(input logic [15:0] c);
      is_trap_code = (c[15:8] == 8'h00) && (c[7:4] == TRAP_CLASS_A || c[7:4] == TRAP_CLASS_B);
   endfunction

   always_comb begin
      n = q;
      n.cancel = 1'b0;
      n.ex_o = 1'b0;
      n.mem_o = 1'b0;
      n.fwd_o = 1'b0;
      n.wb_o = 1'b0;
      n.irq_o = 1'b0;
      n.abort_o = 1'b0;
      n.trap_o = 1'b0;
      n.done_o = 1'b0;
      if (q.discard != 2'h0) begin
         n.cancel = 1'b1;
         n.discard = q.discard - 2'h1;
      end
      unique case (q.st)
         ST_DECODE: begin
            n.ready = 1'b1;
            if (issue_valid && q.ready) begin
               n.op = op_t'(issue_op);
               n.pc = issue_pc;
               n.code = issue_code;
               n.ex_left = EX_ONE;
               n.mem_left = 6'h00;
               n.second_mem = 1'b0;
               n.wait_left = 5'h00;
               n.ready = 1'b0;
               n.st = ST_EXEC;
               unique case (op_t'(issue_op))
                  OP_MOV_IMM32: n.ex_left = EX_IMM32;
                  OP_DIV_SIGNED: n.ex_left = EX_SIGNED_DIV;
                  OP_DIV_UNSIGNED: n.ex_left = EX_UNSIGNED_DIV;
                  OP_BCOND: begin
                     // Target is known here, the back end stays idle
                     if (prev_writes_status && cond_true) begin
                        n.wait_left = FLAG_HAZARD_WAIT;
                        n.st = ST_DECODE2;
                     end else if (cond_true) begin
                        n.discard = DISCARD_ONE;
                        n.st = ST_DECODE;
                        n.done_o = 1'b1;
                     end else begin
                        n.st = ST_DECODE;
                        n.ready = 1'b1;
                        n.done_o = 1'b1;
                     end
                  end
                  OP_BR_JR, OP_JMP, OP_TABLE_CALL_RETURN: begin
                     n.discard = DISCARD_ONE;
                     n.st = ST_DECODE;
                     n.done_o = 1'b1;
                  end
                  OP_JUMP_AND_LINK: begin
                     n.discard = DISCARD_ONE;
                     n.st = ST_WB;
                  end
                  OP_MEMORY_BIT_RMW, OP_MEMORY_BIT_TEST, OP_SWITCH: begin
                     n.mem_left = 6'h01;
                     n.second_mem = (op_t'(issue_op) != OP_MEMORY_BIT_TEST);
                  end
                  OP_TABLE_CALL: begin
                     n.mem_left = 6'h01;
                     n.discard = DISCARD_ONE;
                     n.st = ST_MEM;
                  end
                  OP_FRAME: begin
                     n.mem_left = {1'b0, list_count} + 6'h01;
                     if (frame_branch) begin
                        n.discard = DISCARD_ONE;
                     end
                  end
                  OP_INTERRUPT_RETURN: begin
                     n.discard = DISCARD_TWO;
                     n.st = ST_DECODE2;
                  end
                  OP_TRAP: begin
                     n.st = ST_DECODE2;
                     n.discard = DISCARD_ONE;
                  end
                  OP_SYSREG_READ: begin
                     if (prev_writes_saved_pc && reads_saved_pc) begin
                        n.wait_left = SYSREG_WAIT;
                        n.st = ST_DECODE2;
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end
         ST_DECODE2: begin
            if (q.wait_left > 5'h01) begin
               n.wait_left = q.wait_left - 5'h01;
            end else begin
               n.wait_left = 5'h00;
               unique case (q.op)
                  OP_BCOND: begin
                     n.discard = DISCARD_ONE;
                     n.st = ST_DECODE;
                     n.done_o = 1'b1;
                  end
                  OP_TRAP: begin
                     n.trap_o = is_trap_code(q.code);
                     n.vec_o = TRAP_VEC_BASE + {3'h0, q.code[4:0]};
                     n.st = ST_EXEC;
                  end
                  default: n.st = ST_EXEC;
               endcase
            end
         end
         ST_EXEC: begin
            n.ex_o = 1'b1;
            // Toggle ops and the back end of a divide-free flow ignore requests
            if ((q.op == OP_DIV_SIGNED || q.op == OP_DIV_UNSIGNED) && irq_pending) begin
               n.abort_o = 1'b1;
               n.irq_o = 1'b1;
               n.ret_o = q.pc;
               n.ex_o = 1'b0;
               n.st = ST_DECODE;
            end else if (q.ex_left > EX_ONE) begin
               n.ex_left = q.ex_left - 6'h01;
            end else if (q.mem_left != 6'h00) begin
               n.st = ST_MEM;
            end else if (q.op == OP_HALT) begin
               n.st = ST_HALTED;
            end else if (q.op == OP_IRQ_TOGGLE || q.op == OP_TRAP || q.op == OP_SWITCH ||
                         q.op == OP_INTERRUPT_RETURN || q.op == OP_NOP) begin
               // Switch ends after its second execute, write-back stays idle
               n.st = ST_DECODE;
               n.ready = 1'b1;
               n.done_o = 1'b1;
            end else begin
               n.st = ST_FWD;
            end
         end
         ST_MEM: begin
            n.mem_o = 1'b1;
            if (q.mem_left > 6'h01) begin
               n.mem_left = q.mem_left - 6'h01;
            end else if (q.second_mem || q.op == OP_TABLE_CALL) begin
               n.second_mem = 1'b0;
               n.mem_left = (q.op == OP_MEMORY_BIT_RMW) ? 6'h01 : 6'h00;
               n.ex_left = EX_ONE;
               n.op = (q.op == OP_TABLE_CALL) ? OP_NOP : q.op;
               n.st = ST_EXEC;
            end else begin
               n.mem_left = 6'h00;
               n.st = (q.op == OP_FRAME) ? ST_WB : ST_DECODE;
               n.done_o = (q.op != OP_FRAME);
            end
         end
         ST_FWD: begin
            n.fwd_o = 1'b1;
            n.st = ST_WB;
         end
         ST_WB: begin
            n.wb_o = 1'b1;
            n.st = ST_DECODE;
            n.ready = 1'b1;
            n.done_o = 1'b1;
         end
         ST_HALTED: begin
            if (halt_release) begin
               n.st = ST_DECODE;
               n.done_o = 1'b1;
            end
         end
         default: n.st = ST_DECODE;
      endcase
      // Decode is held while any fetch is still being thrown away
      if (n.st == ST_DECODE && n.discard != 2'h0) begin
         n.ready = 1'b0;
      end else if (n.st == ST_DECODE) begin
         n.ready = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= '{st: ST_DECODE, op: OP_NOP, default: '0};
      end else if (clk_en) begin
         q <= n;
      end
   end

   assign issue_ready = q.ready;
   assign fetch_cancel = q.cancel;
   assign ex_stage = q.ex_o;
   assign mem_stage = q.mem_o;
   assign fwd_stage = q.fwd_o;
   assign wb_write = q.wb_o;
   assign irq_taken = q.irq_o;
   assign return_pc = q.ret_o;
   assign div_abort = q.abort_o;
   assign trap_valid = q.trap_o;
   assign trap_vector = q.vec_o;
   assign instr_done = q.done_o;

   a_halt_holds: assert property (@(posedge clk) disable iff (!reset_n)
      (q.st == ST_HALTED && !halt_release) |=> !issue_ready)
      else $error("Decode released during halt");
   a_div_abort_pc: assert property (@(posedge clk) disable iff (!reset_n)
      div_abort |-> (return_pc == q.pc && irq_taken))
      else $error("Divide abort return point wrong");
   a_taken_cancel: assert property (@(posedge clk) disable iff (!reset_n)
      (clk_en && q.st == ST_DECODE && issue_valid && q.ready && issue_op == OP_BCOND
       && cond_true && !prev_writes_status) |=> ##1 fetch_cancel)
      else $error("Taken branch kept next fetch");
   a_fail_noncancel: assert property (@(posedge clk) disable iff (!reset_n)
      (clk_en && q.st == ST_DECODE && q.discard == 2'h0 && issue_valid && q.ready
       && issue_op == OP_BCOND && !cond_true) |=> (!fetch_cancel && issue_ready))
      else $error("Failed branch stalled");
   a_alu_flow: assert property (@(posedge clk) disable iff (!reset_n)
      (clk_en && q.st == ST_DECODE && issue_valid && q.ready && issue_op == OP_ALU) ##1 clk_en
      |=> (ex_stage ##1 fwd_stage ##1 wb_write))
      else $error("Arithmetic flow wrong");
   a_halt_idle: assert property (@(posedge clk) disable iff (!reset_n)
      (clk_en && q.st == ST_HALTED) [*3] |-> !act.busy)
      else $error("Back end active during halt");
   a_toggle_noirq: assert property (@(posedge clk) disable iff (!reset_n)
      (q.op == OP_IRQ_TOGGLE) |-> !irq_taken)
      else $error("Toggle op sampled interrupt");
   a_ret_discard: assert property (@(posedge clk) disable iff (!reset_n)
      (clk_en && q.st == ST_DECODE && issue_valid && q.ready && issue_op == OP_INTERRUPT_RETURN)
      |=> (q.discard == DISCARD_TWO))
      else $error("Interrupt return discard count wrong");
   a_sysreg_wait: assert property (@(posedge clk) disable iff (!reset_n)
      (clk_en && q.st == ST_DECODE && issue_valid && q.ready && issue_op == OP_SYSREG_READ
       && prev_writes_saved_pc && reads_saved_pc) |=> (q.st == ST_DECODE2))
      else $error("Saved-PC read did not wait");
endmodule

// *** far_side_model.sv ***
// Far-side model that counts activity seen from the sequencer
`timescale 1ns/10ps
module far_side_model (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic fetch_cancel,
   input wire logic ex_stage,
   input wire logic mem_stage,
   input wire logic fwd_stage,
   input wire logic wb_write,
   output logic [15:0] cancels,
   output logic [15:0] execs,
   output logic [15:0] mems,
   output logic [15:0] fwds,
   output logic [15:0] wbs
);
   // Free-running counts; the bench works on differences so no clear is needed
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         {cancels, execs, mems, fwds, wbs} <= '0;
      end else begin
         cancels <= cancels + 16'(fetch_cancel);
         execs <= execs + 16'(ex_stage);
         mems <= mems + 16'(mem_stage);
         fwds <= fwds + 16'(fwd_stage);
         wbs <= wbs + 16'(wb_write);
      end
   end
endmodule

// *** seq_if.sv ***
`timescale 1ns/10ps
// Stage activity bundle between the sequencer and its stage tracker
interface seq_if;
   logic ex_active;
   logic mem_active;
   logic wb_active;
   logic busy;
   modport drive(output ex_active, output mem_active, output wb_active, input busy);
   modport track(input ex_active, input mem_active, input wb_active, output busy);
endinterface

// *** seq_pkg.sv ***
// Constants and types for the pipeline stage sequencer
package seq_pkg;
   localparam int OP_W = 5;
   typedef enum logic [4:0] {
      OP_ALU = 5'h00, OP_MOV_IMM32 = 5'h01, OP_DIV_SIGNED = 5'h02, OP_DIV_UNSIGNED = 5'h03,
      OP_SAT = 5'h04, OP_LOGIC = 5'h05, OP_BCOND = 5'h06, OP_BR_JR = 5'h07,
      OP_JUMP_AND_LINK = 5'h08, OP_JMP = 5'h09, OP_TABLE_CALL_RETURN = 5'h0A,
      OP_MEMORY_BIT_RMW = 5'h0B, OP_MEMORY_BIT_TEST = 5'h0C, OP_TABLE_CALL = 5'h0D,
      OP_IRQ_TOGGLE = 5'h0E, OP_FRAME = 5'h0F, OP_HALT = 5'h10, OP_SYSREG_WRITE = 5'h11,
      OP_SYSREG_READ = 5'h12, OP_INTERRUPT_RETURN = 5'h13, OP_SWITCH = 5'h14,
      OP_TRAP = 5'h15, OP_NOP = 5'h16
   } op_t;
   localparam logic [5:0] EX_SIGNED_DIV = 6'h23;
   localparam logic [5:0] EX_UNSIGNED_DIV = 6'h22;
   localparam logic [5:0] EX_IMM32 = 6'h02;
   localparam logic [5:0] EX_ONE = 6'h01;
   localparam logic [3:0] TRAP_CLASS_A = 4'h4;
   localparam logic [3:0] TRAP_CLASS_B = 4'h5;
   localparam logic [7:0] TRAP_VEC_BASE = 8'h40;
   localparam logic [1:0] DISCARD_ONE = 2'h1;
   localparam logic [1:0] DISCARD_TWO = 2'h2;
   localparam logic [4:0] FLAG_HAZARD_WAIT = 5'h01;
   localparam logic [4:0] SYSREG_WAIT = 5'h02;
   typedef enum logic [6:0] {
      ST_DECODE = 7'b0000001, ST_DECODE2 = 7'b0000010, ST_EXEC = 7'b0000100,
      ST_MEM = 7'b0001000, ST_FWD = 7'b0010000, ST_WB = 7'b0100000,
      ST_HALTED = 7'b1000000
   } stage_t;
endpackage

// *** stage_tracker.sv ***
`timescale 1ns/10ps
// Counts consecutive cycles with an execute, memory or write-back stage active
module stage_tracker
   import seq_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   seq_if.track act
);
   typedef struct packed {
      logic [7:0] cycles;
   } trk_t;
   trk_t q, next_q;
   always_comb begin
      next_q = q;
      if (act.ex_active || act.mem_active || act.wb_active) begin
         next_q.cycles = q.cycles + 8'h01;
      end else begin
         next_q.cycles = 8'h00;
      end
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= '0;
      end else if (clk_en) begin
         q <= next_q;
      end
   end
   assign act.busy = (q.cycles != 8'h00);
endmodule

// *** testbench.sv ***
// Self-checking bench for the pipeline stage sequencer
`timescale 1ns/10ps
module testbench;
   import seq_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic clk_en = 1'b1;
   logic issue_valid = 1'b0;
   logic [4:0] issue_op = 5'h00;
   logic [31:0] issue_pc = 32'h0000_1000;
   logic [15:0] issue_code = 16'h0000;
   logic cond_true = 1'b0, prev_writes_status = 1'b0, prev_writes_saved_pc = 1'b0;
   logic reads_saved_pc = 1'b0, frame_branch = 1'b0, irq_pending = 1'b0, halt_release = 1'b0;
   logic [4:0] list_count = 5'h00;
   logic issue_ready, fetch_cancel, ex_stage, mem_stage, fwd_stage, wb_write;
   logic irq_taken, div_abort, trap_valid, instr_done;
   logic [31:0] return_pc;
   logic [7:0] trap_vector;
   logic [15:0] cancels, execs, mems, fwds, wbs;
   logic [15:0] s_can, s_ex, s_mem, s_fwd, s_wb, d_can, d_ex, d_mem, d_fwd, d_wb;
   logic irq_seen, trap_seen, abort_seen;
   int bad_count = 0;
   int num_checks = 0;
   int lat, rdy, base;

   cpu_pipeline_stage_sequencer i_cpu_pipeline_stage_sequencer (.clk, .reset_n, .clk_en,
      .issue_valid, .issue_op, .issue_pc, .issue_code, .cond_true, .prev_writes_status,
      .prev_writes_saved_pc, .reads_saved_pc, .list_count, .frame_branch, .irq_pending,
      .halt_release, .issue_ready, .fetch_cancel, .ex_stage, .mem_stage, .fwd_stage,
      .wb_write, .irq_taken, .return_pc, .div_abort, .trap_valid, .trap_vector, .instr_done);
   far_side_model i_far_side_model (.clk, .reset_n, .fetch_cancel, .ex_stage, .mem_stage,
      .fwd_stage, .wb_write, .cancels, .execs, .mems, .fwds, .wbs);

   always #12.5 clk = ~clk;

   task automatic end_sim();
      if (bad_count == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
         bad_count++;
      end
   endtask

   // Offer one instruction and hold it until the edge that takes it
   task automatic take(input op_t op, input logic [15:0] code, input logic [4:0] n);
      int k;
      @(negedge clk);
      issue_valid = 1'b1;
      issue_op = op;
      issue_code = code;
      list_count = n;
      issue_pc = issue_pc + 32'h0000_0004;
      k = 0;
      while (issue_ready !== 1'b1 && k < 200) begin
         @(negedge clk);
         k++;
      end
      chk("issue accepted", 1, k < 200);
      {s_can, s_ex, s_mem, s_fwd, s_wb} = {cancels, execs, mems, fwds, wbs};
      @(negedge clk);
      issue_valid = 1'b0;
   endtask

   // Follow the taken instruction to its end; lat to done, rdy to next readiness
   task automatic collect(input int irq_at);
      {irq_seen, trap_seen, abort_seen} = 3'b000;
      for (lat = 1; lat < 100; lat++) begin
         if (lat == irq_at) irq_pending = 1'b1;
         if (irq_taken === 1'b1) irq_seen = 1'b1;
         if (trap_valid === 1'b1) trap_seen = 1'b1;
         if (div_abort === 1'b1) abort_seen = 1'b1;
         if (instr_done === 1'b1 || abort_seen) break;
         @(negedge clk);
      end
      irq_pending = 1'b0;
      chk("instruction end", 1, lat < 100);
      rdy = lat;
      while (issue_ready !== 1'b1 && rdy < 200) begin
         @(negedge clk);
         rdy++;
      end
      // The model counts a stage output one edge after it stands
      @(negedge clk);
      {d_can, d_ex, d_mem} = {cancels - s_can, execs - s_ex, mems - s_mem};
      {d_fwd, d_wb} = {fwds - s_fwd, wbs - s_wb};
   endtask

   task automatic run(input op_t op, input logic [15:0] code, input logic [4:0] n, input int ia);
      take(op, code, n);
      collect(ia);
   endtask

   // A value of FFFF skips that count
   task automatic expect_counts(input logic [15:0] ex, mem, wb, can);
      if (ex != 16'hFFFF) chk("ex_stage count", ex, d_ex);
      if (mem != 16'hFFFF) chk("mem_stage count", mem, d_mem);
      if (wb != 16'hFFFF) chk("wb_write count", wb, d_wb);
      if (can != 16'hFFFF) chk("fetch_cancel count", can, d_can);
   endtask

   task automatic t_simple();
      op_t ops[3] = '{OP_ALU, OP_SAT, OP_LOGIC};
      foreach (ops[i]) begin
         run(ops[i], 16'h0000, 5'h00, 0);
         expect_counts(16'h0001, 16'h0000, 16'h0001, 16'h0000);
         chk("fwd_stage count", 16'h0001, d_fwd);
      end
      run(OP_MOV_IMM32, 16'h0000, 5'h00, 0);
      expect_counts(16'h0002, 16'h0000, 16'h0001, 16'h0000);
   endtask

   task automatic t_divide();
      run(OP_DIV_SIGNED, 16'h0000, 5'h00, 0);
      expect_counts(16'h0023, 16'h0000, 16'h0001, 16'h0000);
      run(OP_DIV_UNSIGNED, 16'h0000, 5'h00, 0);
      expect_counts(16'h0022, 16'h0000, 16'h0001, 16'h0000);
      run(OP_DIV_SIGNED, 16'h0000, 5'h00, 6);
      chk("divide abort", 1, abort_seen);
      chk("interrupt taken", 1, irq_seen);
      chk("return_pc", issue_pc, return_pc);
      chk("aborted writes", 0, d_wb + d_fwd);
   endtask

   task automatic t_branch();
      cond_true = 1'b0;
      run(OP_BCOND, 16'h0000, 5'h00, 0);
      expect_counts(16'h0000, 16'h0000, 16'h0000, 16'h0000);
      chk("not taken clocks", 1, rdy);
      cond_true = 1'b1;
      run(OP_BCOND, 16'h0000, 5'h00, 0);
      expect_counts(16'h0000, 16'h0000, 16'h0000, 16'h0001);
      chk("taken clocks", 2, rdy);
      prev_writes_status = 1'b1;
      run(OP_BCOND, 16'h0000, 5'h00, 0);
      prev_writes_status = 1'b0;
      chk("flag hazard clocks", 3, rdy);
   endtask

   task automatic t_jumps();
      op_t ops[3] = '{OP_BR_JR, OP_JUMP_AND_LINK, OP_JMP};
      logic [15:0] wb[3] = '{16'h0000, 16'h0001, 16'h0000};
      foreach (ops[i]) begin
         run(ops[i], 16'h0000, 5'h00, 0);
         expect_counts(16'h0000, 16'h0000, wb[i], 16'h0001);
      end
      run(OP_TABLE_CALL_RETURN, 16'h0000, 5'h00, 0);
      expect_counts(16'h0000, 16'h0000, 16'h0000, 16'hFFFF);
   endtask

   task automatic t_memory_ops();
      run(OP_MEMORY_BIT_RMW, 16'h0000, 5'h00, 0);
      expect_counts(16'h0002, 16'h0002, 16'h0000, 16'h0000);
      run(OP_MEMORY_BIT_TEST, 16'h0000, 5'h00, 0);
      expect_counts(16'hFFFF, 16'h0001, 16'h0000, 16'h0000);
      run(OP_TABLE_CALL, 16'h0000, 5'h00, 0);
      expect_counts(16'h0001, 16'h0001, 16'h0000, 16'h0001);
      run(OP_SWITCH, 16'h0000, 5'h00, 0);
      expect_counts(16'h0002, 16'h0001, 16'h0000, 16'hFFFF);
      run(OP_FRAME, 16'h0000, 5'h00, 0);
      expect_counts(16'hFFFF, 16'h0001, 16'hFFFF, 16'hFFFF);
      frame_branch = 1'b1;
      run(OP_FRAME, 16'h0000, 5'h03, 0);
      frame_branch = 1'b0;
      expect_counts(16'hFFFF, 16'h0004, 16'hFFFF, 16'hFFFF);
   endtask

   task automatic t_control();
      logic [15:0] codes[4] = '{16'h0040, 16'h004F, 16'h0050, 16'h005F};
      logic [7:0] vecs[4] = '{8'h40, 8'h4F, 8'h50, 8'h5F};
      run(OP_IRQ_TOGGLE, 16'h0000, 5'h00, 1);
      chk("toggle samples irq", 0, irq_seen);
      expect_counts(16'hFFFF, 16'h0000, 16'h0000, 16'hFFFF);
      run(OP_INTERRUPT_RETURN, 16'h0000, 5'h00, 0);
      expect_counts(16'hFFFF, 16'h0000, 16'h0000, 16'h0002);
      foreach (codes[i]) begin
         run(OP_TRAP, codes[i], 5'h00, 0);
         chk("trap_valid", 1, trap_seen);
         chk("trap_vector", vecs[i], trap_vector);
      end
      run(OP_TRAP, 16'h0060, 5'h00, 0);
      chk("trap_valid", 0, trap_seen);
      run(OP_SYSREG_WRITE, 16'h0000, 5'h00, 0);
      reads_saved_pc = 1'b1;
      run(OP_SYSREG_READ, 16'h0000, 5'h00, 0);
      base = rdy;
      prev_writes_saved_pc = 1'b1;
      run(OP_SYSREG_READ, 16'h0000, 5'h00, 0);
      {prev_writes_saved_pc, reads_saved_pc} = 2'b00;
      chk("saved pc wait", base + 2, rdy);
   endtask

   task automatic t_halt();
      take(OP_HALT, 16'h0000, 5'h00);
      issue_valid = 1'b1;
      issue_op = OP_ALU;
      repeat (20) @(negedge clk);
      chk("decode held in halt", 1, (execs - s_ex) <= 16'h0001);
      chk("halt memory and write", 0, (mems - s_mem) + (wbs - s_wb));
      halt_release = 1'b1;
      run(OP_ALU, 16'h0000, 5'h00, 0);
      halt_release = 1'b0;
      expect_counts(16'h0001, 16'h0000, 16'h0001, 16'h0000);
   endtask

   initial begin
      #(25 * 20000);
      bad_count++;
      end_sim();
   end

   initial begin
      repeat (6) @(posedge clk);
      @(negedge clk);
      reset_n = 1'b1;
      t_simple();
      t_divide();
      t_branch();
      t_jumps();
      t_memory_ops();
      t_control();
      t_halt();
      end_sim();
   end
endmodule
